/* File: misc_cmd_pkg.sv */
// Package with opcodes, field layouts and timing constants of the miscellaneous command unit
package misc_cmd_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OUTPUTS = 3'b000,
    OP_POSLOAD = 3'b001,
    OP_RESTART = 3'b010,
    OP_ABORT   = 3'b011,
    OP_NOTE    = 3'b100,
    OP_WAITMV  = 3'b101
  } opcode_t;

  // Per-output action field
  typedef enum logic [1:0] {
    OUT_KEEP = 2'b00,
    OUT_LOW  = 2'b01,
    OUT_HIGH = 2'b10
  } outAct_t;

  // Executor states
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAITMV  = 2'b01,
    ST_RSTHOLD = 2'b10,
    ST_HALTED  = 2'b11
  } state_t;

  // ----------------------------------------------------------------
  // Widths, positions and counts
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int OUT_FIELD_W = 2;
  localparam int NOTE_CHARS = 30;
  localparam int NOTE_W = NOTE_CHARS * 8;
  localparam int POS_W = 32;
  localparam logic [NUM_OUT-1:0] OUT_RESET = 4'h0;
  localparam logic [31:0] POS_RESET = 32'h0000_0000;
  localparam int CLK_HZ = 10_000_000;
  localparam int GUARD_MS = 100;
  localparam int GUARD_CYCLES = (CLK_HZ / 1000) * GUARD_MS;
endpackage : misc_cmd_pkg

/* File: motion_program_misc_commands.sv */
// Executor for the output, position, restart, abort, note and wait-for-move commands
`timescale 1ns/1ns

// Function
// - Each output goes high, low or stays
// - Position load overwrites counter, no motion
// - Restart reinitialises as after power cycle
// - Program restart waits 0.1 s since last
// - Abort stops motion at once, no ramp
// - Abort applies holding current, halts program
// - Note command is a no-operation
// - Note text holds up to 30 characters
// - Wait-for-move stalls until motion completes
// - Position load shifts pending position trigger
module motion_program_misc_commands #(
  parameter int GUARD_CYC = misc_cmd_pkg::GUARD_CYCLES,
  parameter int POSW = misc_cmd_pkg::POS_W
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmdValid,
  input wire misc_cmd_pkg::opcode_t cmdOp,
  input wire logic cmdFromProgram,
  input wire logic [misc_cmd_pkg::NUM_OUT*misc_cmd_pkg::OUT_FIELD_W-1:0] cmdOutSel,
  input wire logic [POSW-1:0] cmdPos,
  input wire logic [misc_cmd_pkg::NOTE_W-1:0] cmdNote,
  input wire logic posStep,
  input wire logic posDir,
  input wire logic trigLoad,
  input wire logic [POSW-1:0] trigLoadVal,
  input wire logic motionBusyPin,
  output logic cmdReady,
  output logic cmdDone,
  output logic [misc_cmd_pkg::NUM_OUT-1:0] gpOut,
  output logic [POSW-1:0] posCount,
  output logic [POSW-1:0] posTrigger,
  output logic motionKill,
  output logic holdCurrentApply,
  output logic programHalt,
  output logic restartReq
);

  // ----------------------------------------------------------------
  // State and synchroniser
  // ----------------------------------------------------------------
  misc_cmd_pkg::state_t state_q, state_d;
  logic busyMeta_q, busySync_q;
  logic [misc_cmd_pkg::NUM_OUT-1:0] gpOut_q;
  logic [POSW-1:0] pos_q, trig_q;
  logic [31:0] guard_q;
  logic done_q, kill_q, hold_q, halt_q, restart_q;
  logic ready_q; // Registered idle flag behind cmdReady
  logic [misc_cmd_pkg::NOTE_W-1:0] noteIgnored;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic accept = cmdValid && (state_q == misc_cmd_pkg::ST_IDLE);
  wire logic doOut = accept && cmdOp == misc_cmd_pkg::OP_OUTPUTS;
  wire logic doPos = accept && cmdOp == misc_cmd_pkg::OP_POSLOAD;
  wire logic doRst = accept && cmdOp == misc_cmd_pkg::OP_RESTART;
  wire logic doAbort = accept && cmdOp == misc_cmd_pkg::OP_ABORT;
  wire logic doNote = accept && cmdOp == misc_cmd_pkg::OP_NOTE;
  wire logic doWait = accept && cmdOp == misc_cmd_pkg::OP_WAITMV;
  wire logic guardOpen = (guard_q == 32'h0000_0000);
  wire logic rstNow = (doRst && (!cmdFromProgram || guardOpen))
    || (state_q == misc_cmd_pkg::ST_RSTHOLD && guardOpen);
  wire logic [POSW-1:0] stepDelta = posStep ? (posDir ? {POSW{1'b1}} : {{(POSW-1){1'b0}}, 1'b1}) : '0;
  wire logic [POSW-1:0] posShift = cmdPos - pos_q;
  wire logic simpleDone = doOut || doPos || doNote
    || (doWait && !busySync_q) || (state_q == misc_cmd_pkg::ST_WAITMV && !busySync_q);

  assign noteIgnored = cmdNote;

  // Next-output selection per output
  logic [misc_cmd_pkg::NUM_OUT-1:0] gpOut_d;
  genvar gi;
  generate
    for (gi = 0; gi < misc_cmd_pkg::NUM_OUT; gi++) begin : g_out
      wire logic [1:0] sel = cmdOutSel[gi*2 +: 2];
      assign gpOut_d[gi] = !doOut ? gpOut_q[gi] :
        (sel == misc_cmd_pkg::OUT_HIGH) ? 1'b1 :
        (sel == misc_cmd_pkg::OUT_LOW) ? 1'b0 : gpOut_q[gi];
    end
  endgenerate

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      misc_cmd_pkg::ST_IDLE: begin
        if (doWait && busySync_q) state_d = misc_cmd_pkg::ST_WAITMV;
        else if (doRst && !rstNow) state_d = misc_cmd_pkg::ST_RSTHOLD;
        else if (doAbort) state_d = misc_cmd_pkg::ST_HALTED;
      end
      misc_cmd_pkg::ST_WAITMV: if (!busySync_q) state_d = misc_cmd_pkg::ST_IDLE;
      misc_cmd_pkg::ST_RSTHOLD: if (guardOpen) state_d = misc_cmd_pkg::ST_IDLE;
      misc_cmd_pkg::ST_HALTED: state_d = misc_cmd_pkg::ST_HALTED;
    endcase
    if (rstNow) state_d = misc_cmd_pkg::ST_IDLE;
  end

  // Pin synchroniser
  always_ff @(posedge clk_sys) begin
    busyMeta_q <= nrst ? motionBusyPin : 1'b0;
    busySync_q <= nrst ? busyMeta_q : 1'b0;
  end

  // Control state
  always_ff @(posedge clk_sys) begin
    if (!nrst || rstNow) begin
      state_q <= misc_cmd_pkg::ST_IDLE;
      gpOut_q <= misc_cmd_pkg::OUT_RESET;
      kill_q <= 1'b0;
      hold_q <= 1'b0;
      halt_q <= 1'b0;
      done_q <= 1'b0;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == misc_cmd_pkg::ST_IDLE);
      gpOut_q <= gpOut_d;
      done_q <= simpleDone;
      kill_q <= doAbort;
      hold_q <= hold_q || doAbort;
      halt_q <= halt_q || doAbort;
    end
  end

  // Restart pulse and guard counter
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      restart_q <= 1'b0;
      guard_q <= 32'(GUARD_CYC);
    end else begin
      restart_q <= rstNow;
      guard_q <= rstNow ? 32'(GUARD_CYC) : (guardOpen ? guard_q : guard_q - 32'h0000_0001);
    end
  end

  // Position counter and trigger
  always_ff @(posedge clk_sys) begin
    if (!nrst || rstNow) begin
      pos_q <= POSW'(misc_cmd_pkg::POS_RESET);
      trig_q <= POSW'(misc_cmd_pkg::POS_RESET);
    end else begin
      pos_q <= doPos ? cmdPos : pos_q + stepDelta;
      trig_q <= trigLoad ? trigLoadVal : (doPos ? trig_q + posShift : trig_q);
    end
  end

  // ----------------------------------------------------------------
  // Outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign cmdReady = ready_q;
  assign cmdDone = done_q;
  assign gpOut = gpOut_q;
  assign posCount = pos_q;
  assign posTrigger = trig_q;
  assign motionKill = kill_q;
  assign holdCurrentApply = hold_q;
  assign programHalt = halt_q;
  assign restartReq = restart_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Output commands; both keep codes must leave the pin alone
  a_out_high_set: assert property (doOut && cmdOutSel[1:0] == 2'b10 && !rstNow |=> gpOut[0])
    else $error("output not driven high");
  a_out_keep: assert property (doOut && (cmdOutSel[3:2] == 2'b00 || cmdOutSel[3:2] == 2'b11) && !rstNow
    |=> $stable(gpOut[1]))
    else $error("kept output changed");

  // Position counter and the trigger that follows it
  a_pos_load: assert property (doPos && !rstNow |=> posCount == $past(cmdPos))
    else $error("position not loaded");
  a_pos_hold: assert property (!doPos && !posStep && !rstNow |=> $stable(posCount))
    else $error("position moved unasked");
  a_trig_shift: assert property (doPos && !trigLoad && !rstNow
    |=> posTrigger - posCount == $past(posTrigger) - $past(posCount))
    else $error("trigger offset lost");

  // Restart and its guard interval
  a_restart_clear: assert property (rstNow |=> gpOut == 4'h0 && restartReq && !programHalt)
    else $error("restart did not reinit");
  a_ready_restart: assert property (restartReq |-> cmdReady && !motionKill && !holdCurrentApply)
    else $error("restart left state behind");
  a_restart_guard: assert property (doRst && cmdFromProgram && !guardOpen |=> !restartReq)
    else $error("restart inside guard");
  a_guard_hold: assert property (state_q == misc_cmd_pkg::ST_RSTHOLD && !guardOpen |=> !restartReq)
    else $error("held restart ran early");

  // Abort, note, wait and ordering
  a_abort_kill: assert property (doAbort && !rstNow |=> motionKill && programHalt && holdCurrentApply)
    else $error("abort incomplete");
  a_halt_ready: assert property (programHalt |-> !cmdReady)
    else $error("halted yet ready");
  a_halt_sticky: assert property (programHalt |=> programHalt && holdCurrentApply)
    else $error("halt flags dropped");
  a_note_noop: assert property (doNote && !rstNow |=> $stable(gpOut) && cmdDone && !motionKill)
    else $error("note had effect");
  a_wait_stall: assert property (doWait && busySync_q |=> !cmdReady)
    else $error("wait did not stall");
  a_wait_release: assert property (state_q == misc_cmd_pkg::ST_WAITMV && !busySync_q
    |=> cmdDone && cmdReady)
    else $error("wait did not release");
  a_one_at_time: assert property (cmdValid && !cmdReady && state_q != misc_cmd_pkg::ST_WAITMV
    |=> !cmdDone && !motionKill)
    else $error("accepted while busy");

  // ----------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------
  c_outputs: cover property (doOut);
  c_abort: cover property (doAbort);
  c_wait_done: cover property (state_q == misc_cmd_pkg::ST_WAITMV ##1 cmdReady);
  c_guarded_rst: cover property (state_q == misc_cmd_pkg::ST_RSTHOLD ##1 restartReq);
  c_refused: cover property (cmdValid && !cmdReady && programHalt);

endmodule // motion_program_misc_commands

/* File: motor_stage.sv */
// Behavioural motor stage that steps while a move runs
`timescale 1ns/1ns
module motor_stage (
  input wire logic clk_sys,
  input wire logic startMove,
  input wire logic [7:0] moveLen,
  input wire logic motionKill,
  output logic motionBusyPin,
  output logic posStep
);
  logic [7:0] left_q = 8'h00;
  // Counts the steps left; a kill ends the move with no ramp
  always @(posedge clk_sys) begin
    if (motionKill) left_q <= 8'h00;
    else if (startMove) left_q <= moveLen;
    else if (left_q != 8'h00) left_q <= left_q - 8'h01;
  end
  assign motionBusyPin = (left_q != 8'h00);
  assign posStep = motionBusyPin; // One step per busy cycle
endmodule // motor_stage

/* File: tb.sv */
// Self-checking testbench of the miscellaneous command unit
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic cmdValid = 1'b0;
  misc_cmd_pkg::opcode_t cmdOp = misc_cmd_pkg::OP_NOTE;
  logic cmdFromProgram = 1'b0;
  logic [7:0] cmdOutSel = 8'h00;
  logic [31:0] cmdPos = 32'h0;
  logic [239:0] cmdNote = {30{8'h41}}; // Full 30-character text
  logic trigLoad = 1'b0;
  logic [31:0] trigLoadVal = 32'h100;
  logic startMove = 1'b0;
  logic [7:0] moveLen = 8'h0a;
  logic posDir = 1'b0;
  logic posStep, motionBusyPin, cmdReady, cmdDone, motionKill, holdCurrentApply, programHalt, restartReq;
  logic [3:0] gpOut;
  logic [31:0] posCount, posTrigger;
  int errors = 0;
  int tests_run = 0;
  int n;
  always #50 clk_sys = ~clk_sys;
  motion_program_misc_commands #(.GUARD_CYC(20)) dut_u (.clk_sys(clk_sys), .nrst(nrst), .cmdValid(cmdValid),
    .cmdOp(cmdOp), .cmdFromProgram(cmdFromProgram), .cmdOutSel(cmdOutSel), .cmdPos(cmdPos), .cmdNote(cmdNote),
    .posStep(posStep), .posDir(posDir), .trigLoad(trigLoad), .trigLoadVal(trigLoadVal),
    .motionBusyPin(motionBusyPin), .cmdReady(cmdReady), .cmdDone(cmdDone), .gpOut(gpOut), .posCount(posCount),
    .posTrigger(posTrigger), .motionKill(motionKill), .holdCurrentApply(holdCurrentApply),
    .programHalt(programHalt), .restartReq(restartReq));
  motor_stage stage_u (.clk_sys(clk_sys), .startMove(startMove), .moveLen(moveLen), .motionKill(motionKill),
    .motionBusyPin(motionBusyPin), .posStep(posStep));
  // Compares and counts
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for a flag (0 ready, 1 done, 2 restart), cycle count left in n
  task automatic await(input int which, input int lim);
    n = 0;
    while ((which == 0 ? cmdReady : (which == 1 ? cmdDone : restartReq)) !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > lim) begin
        errors++;
        summarize();
      end
    end
  endtask
  // Offers one command once ready and drops it after the taking edge
  task automatic issue(input misc_cmd_pkg::opcode_t op, input logic [31:0] pos, input logic prog);
    await(0, 50);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdPos = pos;
    cmdFromProgram = prog;
    @(negedge clk_sys);
    cmdValid = 1'b0;
  endtask
  task automatic move(input logic [7:0] len);
    moveLen = len;
    startMove = 1'b1;
    @(negedge clk_sys);
    startMove = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // Back-to-back output commands with every field action
  task automatic t_out();
    cmdOp = misc_cmd_pkg::OP_OUTPUTS;
    cmdOutSel = 8'ha6;
    cmdValid = 1'b1;
    @(negedge clk_sys);
    chk({cmdDone, gpOut}, 5'h1d);
    cmdOutSel = 8'h4c;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    chk({cmdDone, gpOut}, 5'h15);
  endtask
  task automatic t_pos();
    trigLoad = 1'b1;
    @(negedge clk_sys);
    trigLoad = 1'b0;
    issue(misc_cmd_pkg::OP_POSLOAD, 32'h40, 1'b0);
    chk({cmdDone, motionKill, posCount}, {2'h2, 32'h40});
    chk(posTrigger, 32'h140);
    @(negedge clk_sys);
  endtask
  task automatic t_note();
    issue(misc_cmd_pkg::OP_NOTE, 32'h99, 1'b1);
    chk({cmdDone, gpOut, posCount}, {5'h15, 32'h40});
    @(negedge clk_sys);
  endtask
  task automatic t_wait();
    move(8'h0a);
    issue(misc_cmd_pkg::OP_WAITMV, 32'h0, 1'b1);
    chk(cmdReady, 1'h0);
    await(1, 40);
    chk(posCount, 32'h4a);
    @(negedge clk_sys);
  endtask
  task automatic t_restart();
    issue(misc_cmd_pkg::OP_RESTART, 32'h0, 1'b0);
    chk({restartReq, gpOut, posCount}, {5'h10, 32'h0});
    chk({posTrigger, cmdReady}, {32'h0, 1'b1});
    @(negedge clk_sys);
    issue(misc_cmd_pkg::OP_RESTART, 32'h0, 1'b1);
    chk(cmdReady, 1'h0);
    await(2, 100);
    // Guard of 20 cycles from the first restart: at least 18 falling edges here
    chk(n >= 18, 1'h1);
    @(negedge clk_sys);
  endtask
  // Abort during a move in the minus direction, then a refused command
  task automatic t_abort();
    posDir = 1'b1;
    move(8'h32);
    issue(misc_cmd_pkg::OP_ABORT, 32'h0, 1'b1);
    chk(motionKill, 1'h1);
    @(negedge clk_sys);
    chk({motionBusyPin, posCount}, {1'b0, 32'hffff_fffb});
    chk({holdCurrentApply, programHalt, cmdReady}, 3'h6);
    cmdOp = misc_cmd_pkg::OP_OUTPUTS;
    cmdOutSel = 8'haa;
    cmdValid = 1'b1;
    @(negedge clk_sys);
    cmdValid = 1'b0;
    chk({cmdDone, gpOut, programHalt}, 6'h01);
  endtask
  initial begin
    repeat (3) @(negedge clk_sys);
    nrst = 1'b1;
    t_out();
    t_pos();
    t_note();
    t_wait();
    t_restart();
    t_abort();
    summarize();
  end
endmodule // tb
